//--- include/plmux_pkg.sv
// Constants and types for the lower-port pin function multiplexer.
// Assumes a 32-bit AXI4-Lite slave with byte addresses of five bits.
`default_nettype none
package plmux_pkg;
  // Register byte offsets.
  localparam logic [4:0] MODE_OFS = 5'h00;
  localparam logic [4:0] DIR_OFS = 5'h04;
  localparam logic [4:0] PULL_OFS = 5'h08;
  localparam logic [4:0] DATA_OFS = 5'h0C;
  localparam logic [4:0] PWR_OFS = 5'h10;
  localparam logic [4:0] CONV_OFS = 5'h14;
  localparam logic [4:0] PIN_OFS = 5'h18;
  // Reset values.
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  // Mode register bit positions.
  localparam int INT4_SEL_BIT = 4;
  localparam int CAPT_SEL_BIT = 3;
  localparam int OVFH_SEL_BIT = 2;
  localparam int OVFL_SEL_BIT = 1;
  localparam int WATCH_SEL_BIT = 0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Operating modes of the chip.
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b000,
    PWR_SUBACTIVE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_SUBSLEEP = 3'b011,
    PWR_WATCH = 3'b100,
    PWR_STANDBY = 3'b101
  } plmux_pwr_t;
endpackage
`default_nettype wire

//--- verilog/plmux_top.sv
// Pin function multiplexer and power-mode pin control for the lower five
// pins of an eight-bit port, pull-ups for all eight, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to clk; pads resolve out/oe/pull-up.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module plmux_top #(
  parameter int PINS = 5,
  parameter int PORT_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address and data.
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads.
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PORT_W-1:0] pullup_en,
  // Timer outputs to be driven onto pins.
  input wire logic ovf_high_in,
  input wire logic ovf_low_in,
  input wire logic watch_timer_in,
  // Peripheral inputs taken from pins, idle high.
  output logic ext_int_line_four_sel,
  output logic conv_ext_trigger_in,
  output logic capture_input_sel
);

  typedef struct packed {
    logic [7:0] mode;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] pull;
    logic [PINS-1:0] data;
    logic [2:0] pwr;
    logic conv_trigger_enable;
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
    logic [PORT_W-1:0] pull_en;
    logic aw_ok;
    logic [4:0] awaddr;
    logic w_ok;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } plmux_state_t;

  plmux_state_t st_r;
  plmux_state_t st_nxt;

  // Shared decode of read and write addresses.
  function automatic logic addr_ok(input logic [4:0] a);
    addr_ok = (a == plmux_pkg::MODE_OFS) || (a == plmux_pkg::DIR_OFS) ||
      (a == plmux_pkg::PULL_OFS) || (a == plmux_pkg::DATA_OFS) ||
      (a == plmux_pkg::PWR_OFS) || (a == plmux_pkg::CONV_OFS) ||
      (a == plmux_pkg::PIN_OFS);
  endfunction

  logic functional;
  logic holding;
  logic [PINS-1:0] fn_out;
  logic [PINS-1:0] fn_oe;
  logic [PINS-1:0] port_rd;

  // Handshake readies are combinational; one write and one read at a time.
  assign s_axi_awready = !st_r.aw_ok && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_ok && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h000000, st_r.rdata};
  assign pin_out = st_r.out;
  assign pin_oe = st_r.oe;
  assign pullup_en = st_r.pull_en;

  // Peripheral inputs see the pin only when selected, else idle high.
  assign ext_int_line_four_sel = st_r.mode[plmux_pkg::INT4_SEL_BIT] ?
    pin_in[4] : 1'b1;
  assign conv_ext_trigger_in =
    (st_r.mode[plmux_pkg::INT4_SEL_BIT] && st_r.conv_trigger_enable) ?
    pin_in[4] : 1'b1;
  assign capture_input_sel = st_r.mode[plmux_pkg::CAPT_SEL_BIT] ?
    pin_in[3] : 1'b1;

  // Power modes: only active modes follow settings; sleeps freeze pins.
  assign functional = (st_r.pwr == plmux_pkg::PWR_ACTIVE) ||
    (st_r.pwr == plmux_pkg::PWR_SUBACTIVE);
  assign holding = (st_r.pwr == plmux_pkg::PWR_SLEEP) ||
    (st_r.pwr == plmux_pkg::PWR_SUBSLEEP) ||
    (st_r.pwr == plmux_pkg::PWR_WATCH);

  // Pin function per bit; a selected function ignores the direction bit.
  always_comb
  begin
    fn_out = st_r.data;
    fn_oe = st_r.dir[PINS-1:0];
    if (st_r.mode[plmux_pkg::INT4_SEL_BIT])
    begin
      fn_oe[4] = 1'b0;
    end
    if (st_r.mode[plmux_pkg::CAPT_SEL_BIT])
    begin
      fn_oe[3] = 1'b0;
    end
    if (st_r.mode[plmux_pkg::OVFH_SEL_BIT])
    begin
      fn_out[2] = ovf_high_in;
      fn_oe[2] = 1'b1;
    end
    if (st_r.mode[plmux_pkg::OVFL_SEL_BIT])
    begin
      fn_out[1] = ovf_low_in;
      fn_oe[1] = 1'b1;
    end
    if (st_r.mode[plmux_pkg::WATCH_SEL_BIT])
    begin
      fn_out[0] = watch_timer_in;
      fn_oe[0] = 1'b1;
    end
    // Output pins read back the latch, inputs the pad.
    port_rd = (st_r.data & fn_oe) | (pin_in & ~fn_oe);
  end

  // Next state: bus slave, register writes, pad drive and pull-ups.
  always_comb
  begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
    end
    if (st_r.aw_ok && st_r.w_ok)
    begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_ok(st_r.awaddr) ? plmux_pkg::RESP_OKAY :
        plmux_pkg::RESP_SLVERR;
      if (st_r.wlane)
      begin
        unique case (st_r.awaddr)
          plmux_pkg::MODE_OFS: st_nxt.mode = st_r.wdata;
          plmux_pkg::DIR_OFS: st_nxt.dir = st_r.wdata[PORT_W-1:0];
          plmux_pkg::PULL_OFS: st_nxt.pull = st_r.wdata[PORT_W-1:0];
          plmux_pkg::DATA_OFS: st_nxt.data = st_r.wdata[PINS-1:0];
          plmux_pkg::PWR_OFS:
          begin
            // Unknown codes are dropped so the mode stays legal.
            if (st_r.wdata[2:0] <= 3'h5)
            begin
              st_nxt.pwr = st_r.wdata[2:0];
            end
          end
          plmux_pkg::CONV_OFS: st_nxt.conv_trigger_enable = st_r.wdata[0];
          default: st_nxt.pwr = st_r.pwr;
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = addr_ok(s_axi_araddr) ? plmux_pkg::RESP_OKAY :
        plmux_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        plmux_pkg::MODE_OFS: st_nxt.rdata = st_r.mode;
        plmux_pkg::DIR_OFS: st_nxt.rdata = 8'(st_r.dir);
        plmux_pkg::PULL_OFS: st_nxt.rdata = 8'(st_r.pull);
        plmux_pkg::DATA_OFS: st_nxt.rdata = 8'(port_rd);
        plmux_pkg::PWR_OFS: st_nxt.rdata = {5'h00, st_r.pwr};
        plmux_pkg::CONV_OFS: st_nxt.rdata = {7'h00, st_r.conv_trigger_enable};
        plmux_pkg::PIN_OFS: st_nxt.rdata = 8'(pin_in);
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    // Pull-up follows input direction and enable bit.
    st_nxt.pull_en = ~st_r.dir & st_r.pull;
    if (functional)
    begin
      st_nxt.out = fn_out;
      st_nxt.oe = fn_oe;
    end
    else if (!holding)
    begin
      // Standby floats the driver; pull-ups lift enabled pins high.
      st_nxt.oe = '0;
      st_nxt.out = '1;
    end
  end

  // One register for all state; reset floats every pad.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence int4_sel_s;
    st_r.mode[plmux_pkg::INT4_SEL_BIT] && functional;
  endsequence

  bit4_input_a: assert property (int4_sel_s |=> !pin_oe[4])
    else $error("bit-4 pin drives while interrupt input is selected");
  trig_route_a: assert property ((st_r.mode[4] && st_r.conv_trigger_enable) |->
    conv_ext_trigger_in == pin_in[4] && ext_int_line_four_sel == pin_in[4])
    else $error("converter trigger not routed from bit-4 pin");
  capt_input_a: assert property ((st_r.mode[3] && functional) |=>
    !pin_oe[3])
    else $error("bit-3 pin drives while capture input is selected");
  ovf_out_a: assert property ((st_r.mode[2] && functional) |=>
    pin_oe[2] && pin_out[2] == $past(ovf_high_in))
    else $error("bit-2 pin does not carry the high overflow output");
  watch_out_a: assert property ((st_r.mode[0] && functional) |=>
    pin_oe[0] && pin_out[0] == $past(watch_timer_in))
    else $error("bit-0 pin does not carry the watch timer output");
  hold_state_a: assert property (holding |=>
    $stable(pin_oe) && $stable(pin_out))
    else $error("pins changed in a holding mode");
  standby_float_a: assert property (
    (st_r.pwr == plmux_pkg::PWR_STANDBY) |=> pin_oe == '0 &&
    pin_out == '1)
    else $error("standby pins not floating high");
  pullup_rule_a: assert property (##1 pullup_en ==
    $past(~st_r.dir & st_r.pull))
    else $error("pull-up enable wrong for direction and control");
  reset_pins_a: assert property ($rose(nrst) |->
    pin_oe == '0 && pullup_en == '0 && st_r.mode == plmux_pkg::MODE_RST)
    else $error("pins, pull-ups or mode not cleared by reset");

endmodule // plmux_top

`default_nettype wire

//--- verif/plmux_timer_model.sv
// Behavioural far side of the port: timers and the interrupt controller.
// Assumes the same clock and synchronous active-low reset as the port.
`timescale 1ns/100ps
`default_nettype none
module plmux_timer_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Bench controls: timer levels wanted and interrupt-four enable.
  input wire logic [2:0] lvl_req,
  input wire logic int_four_enable,
  // Timer outputs towards the port.
  output logic ovf_high_in,
  output logic ovf_low_in,
  output logic watch_timer_in,
  // Interrupt line from the port and the count of requests taken.
  input wire logic ext_int_line_four_sel,
  output logic [7:0] int_four_cnt_r
);
  logic int_prev_r;

  // Timer levels come from a flop, as a real timer output would.
  // Falling edges of the active-low line count only while enabled.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      {ovf_high_in, ovf_low_in, watch_timer_in} <= 3'h0;
      int_prev_r <= 1'h1;
      int_four_cnt_r <= 8'h00;
    end
    else
    begin
      {ovf_high_in, ovf_low_in, watch_timer_in} <= lvl_req;
      int_prev_r <= ext_int_line_four_sel;
      if (int_four_enable && int_prev_r && !ext_int_line_four_sel)
        int_four_cnt_r <= int_four_cnt_r + 8'h01;
    end
  end
endmodule // plmux_timer_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the lower-port pin multiplexer.
// Assumes the timer model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] mode, dir, pull;
    logic conv_trigger_enable;
    logic [4:0] pin, oe;
    logic [7:0] pu;
    logic [2:0] sel;
  } plmux_row_t;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, int_en;
  logic awready, wready, bvalid, arready, rvalid, ovfh, ovfl, wtim;
  logic int4, trig, capt;
  logic [4:0] awaddr, araddr, pin_in, pin_out, pin_oe;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] pullup_en, icnt;
  logic [2:0] lvl;
  int err_count, n_tests;
  plmux_row_t rows [6];

  plmux_top u_plmux_top (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .ovf_high_in(ovfh),
    .ovf_low_in(ovfl), .watch_timer_in(wtim), .ext_int_line_four_sel(int4),
    .conv_ext_trigger_in(trig), .capture_input_sel(capt));
  plmux_timer_model u_plmux_timer_model (.clk(clk), .nrst(nrst),
    .lvl_req(lvl), .int_four_enable(int_en), .ovf_high_in(ovfh),
    .ovf_low_in(ovfl), .watch_timer_in(wtim), .ext_int_line_four_sel(int4),
    .int_four_cnt_r(icnt));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, where the values equal
  // those the next rising edge samples, so no race with design flops.
  // Each task first waits for a rising edge, so every drive lands on one.
  task axw(input logic [4:0] a, input logic [7:0] d);
    logic at, wt, bt;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      rs = bresp;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
    while (!bt);
    bready <= 1'b0;
  endtask

  task axr(input logic [4:0] a);
    logic at, rt;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      at = arvalid && arready;
      rt = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
    end
    while (!rt);
    rready <= 1'b0;
  endtask

  task gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // A hang ends the run through the same closing task.
  initial
  begin
    repeat (6000) @(posedge clk);
    err_count++;
    close_out;
  end

  // Main sequence: reset, table of pin settings, then awkward cases.
  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, pin_in, wdata, lvl, int_en} = 51'h0;
    rows = '{'{8'h00, 8'h1F, 8'hFF, 1'h0, 5'h1F, 5'h1F, 8'hE0, 3'h7},
      '{8'h00, 8'h00, 8'h0A, 1'h0, 5'h15, 5'h00, 8'h0A, 3'h7},
      '{8'h1F, 8'h1F, 8'hFF, 1'h0, 5'h00, 5'h07, 8'hE0, 3'h2},
      '{8'h1F, 8'h00, 8'h1F, 1'h1, 5'h00, 5'h07, 8'h1F, 3'h0},
      '{8'h10, 8'h00, 8'h00, 1'h1, 5'h1F, 5'h00, 8'h00, 3'h7},
      '{8'h08, 8'h08, 8'h00, 1'h1, 5'h00, 5'h00, 8'h00, 3'h6}};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    gap(1);
    chk(pin_oe, 5'h00);
    chk(pullup_en, 8'h00);
    axr(plmux_pkg::MODE_OFS);
    chk(rd, 32'h00000000);
    lvl <= 3'h2; // Timer levels differ from the data latch bits.
    axw(plmux_pkg::DATA_OFS, 8'h15);
    foreach (rows[i])
    begin
      @(posedge clk);
      pin_in <= rows[i].pin;
      int_en <= !rows[i].conv_trigger_enable;
      axw(plmux_pkg::MODE_OFS, rows[i].mode);
      axw(plmux_pkg::DIR_OFS, rows[i].dir);
      axw(plmux_pkg::PULL_OFS, rows[i].pull);
      axw(plmux_pkg::CONV_OFS, {7'h00, rows[i].conv_trigger_enable});
      gap(3);
      chk(pin_oe, rows[i].oe);
      chk(pin_out & rows[i].oe, ((5'h15 & ~rows[i].mode[4:0]) |
        ({2'h0, lvl} & rows[i].mode[4:0])) & rows[i].oe);
      chk(pullup_en, rows[i].pu);
      chk({int4, trig, capt}, rows[i].sel);
    end
    // Of the three rows with the interrupt enabled, only the third drives a falling edge.
    chk(icnt, 8'h01);
    // Sleep freezes the drivers; waking releases the new setting.
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_SLEEP});
    axw(plmux_pkg::MODE_OFS, 8'h00);
    axw(plmux_pkg::DIR_OFS, 8'h1F);
    gap(3);
    chk(pin_oe, 5'h00);
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_SUBACTIVE});
    gap(3);
    chk(pin_oe, 5'h1F);
    // Standby floats the drivers but keeps the pull-up on pin zero.
    axw(plmux_pkg::DIR_OFS, 8'h1E);
    axw(plmux_pkg::PULL_OFS, 8'h01);
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_STANDBY});
    gap(3);
    chk(pin_oe, 5'h00);
    chk(pullup_en, 8'h01);
    chk(pin_out, 5'h1F);
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_ACTIVE});
    // Watch and subsleep hold the drivers; an unknown code is dropped.
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_WATCH});
    axw(plmux_pkg::DIR_OFS, 8'h01);
    axw(plmux_pkg::PWR_OFS, 8'h07);
    chk(rs, plmux_pkg::RESP_OKAY);
    axr(plmux_pkg::PWR_OFS);
    chk(rd, 32'h00000004);
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_SUBSLEEP});
    axw(plmux_pkg::DIR_OFS, 8'h1F);
    gap(3);
    chk(pin_oe, 5'h1E);
    axw(plmux_pkg::PWR_OFS, {5'h00, plmux_pkg::PWR_ACTIVE});
    gap(3);
    chk(pin_oe, 5'h1F);
    axr(plmux_pkg::DATA_OFS);
    chk(rd, 32'h00000015);
    chk(rs, plmux_pkg::RESP_OKAY);
    // An unmapped place answers with an error and reads as zero.
    axr(5'h1C);
    chk(rd, 32'h00000000);
    chk(rs, plmux_pkg::RESP_SLVERR);
    axw(5'h1C, 8'hFF);
    chk(rs, plmux_pkg::RESP_SLVERR);
    // A second reset in mid-run clears drivers, pull-ups and modes.
    axw(plmux_pkg::MODE_OFS, 8'h1F);
    axw(plmux_pkg::PULL_OFS, 8'hFF);
    nrst <= 1'b0;
    gap(2);
    chk(pin_oe, 5'h00);
    chk(pullup_en, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    gap(1);
    axr(plmux_pkg::MODE_OFS);
    chk(rd, 32'h00000000);
    close_out;
  end
endmodule // tb
`default_nettype wire
